/* File: core/serial_port_map.vh */
// Offsets, field positions, reset values and widths of the serial register ports
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

// Access word layout
`define WORD_W          16
`define RW_BIT          0
`define ADDR_LSB        1
`define ADDR_MSB        5
`define DATA_LSB        6
`define DATA_MSB        15
`define ADDR_W          5
`define DATA_W          10
`define RW_WRITE        1'b0
`define RW_READ         1'b1

// Page select register and its fields
`define PAGE_SEL_ADDR   5'h01
`define PAGE_SEL_RESET  10'h000
`define MICRO_P0_BIT    0
`define MICRO_P1_BIT    1
`define BB_P0_BIT       2
`define BB_P1_BIT       3
`define PAGE_RESET      1'b0

// Register file reset value
`define REG_RESET       10'h000

// Timing serial port word
`define TIMING_W        7
`define UL_POWER_BIT    6
`define UL_CAL_BIT      5
`define UL_TX_BIT       4
`define DL_POWER_BIT    3
`define DL_CAL_BIT      2
`define DL_RX_BIT       1
`define ADC_CONV_BIT    0
`define TIMING_RESET    7'h00

`endif

/* File: core/serial_word_port.v */
// Serial shift engine for one 16-bit register access port
module serial_word_port #(
    parameter WORD_W = 16,
    parameter CNT_W  = 4
) (
    // Clock and reset
    input  wire              clock_i,
    input  wire              rst_b_i,
    // Serial pins
    input  wire              frame_i,
    input  wire              shift_i,
    input  wire              din_i,
    output wire              dout_o,
    // Reply word to send in the next frame
    input  wire [WORD_W-1:0] reply_i,
    input  wire              reply_load_i,
    // Received word
    output reg  [WORD_W-1:0] word_o,
    output reg               word_valid_o
);

    reg [WORD_W-1:0] in_q;
    reg [WORD_W-1:0] out_q;
    reg [CNT_W-1:0]  cnt_q;

    wire last_bit = (cnt_q == {CNT_W{1'b1}});

    // Bit 0 travels first in both directions
    assign dout_o = out_q[0];

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            in_q         <= {WORD_W{1'b0}};
            out_q        <= {WORD_W{1'b0}};
            cnt_q        <= {CNT_W{1'b0}};
            word_o       <= {WORD_W{1'b0}};
            word_valid_o <= 1'b0;
        end else begin
            word_valid_o <= 1'b0;
            if (!frame_i) begin
                cnt_q <= {CNT_W{1'b0}};
            end else if (shift_i) begin
                in_q  <= {din_i, in_q[WORD_W-1:1]};
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                if (last_bit) begin
                    word_o       <= {din_i, in_q[WORD_W-1:1]};
                    word_valid_o <= 1'b1;
                end
            end
            if (reply_load_i) begin
                out_q <= reply_i;
            end else if (frame_i && shift_i) begin
                out_q <= {1'b0, out_q[WORD_W-1:1]};
            end
        end
    end

endmodule // serial_word_port

/* File: core/serial_register_access_ports.v */
// Register bank reached by the baseband and micro serial ports, plus the timing window port
`include "serial_port_map.vh"

// What this block does
// [RQ1] Access word with bit 0 low is taken as a register write.
// [RQ2] Access word with bit 0 high is taken as a register read.
// [RQ3] Bits 1 to 5 carry the register address, A0 at bit 1.
// [RQ4] On a write, bits 6 to 15 carry data D0 to D9 into the register.
// [RQ5] On a read, bits 6 to 15 of the request are ignored.
// [RQ6] Micro port reaches every internal register with the same word layout.
// [RQ7] Baseband port also reads and writes every internal register with 16-bit words.
// [RQ8] Radio burst words cross the baseband port as 16 bits, D0 at bit 0.
// [RQ9] Page select register sits at address 1 on both pages.
// [RQ10] Micro page bits choose page 0 or page 1 for later micro accesses.
// [RQ11] Baseband page bits choose its own page 0 or page 1 independently.
// [RQ12] Timing word bits 6, 5, 4 drive uplink power, calibration, transmit windows.
// [RQ13] Timing word bits 3, 2, 1 drive downlink power, calibration, receive windows.
// [RQ14] Timing word bit 0 opens the auxiliary conversion window.
// [RQ15] Page bits are write-only, reset to zero, page 0; upper bits do nothing.
module serial_register_access_ports #(
    parameter ADDR_W = 5,
    parameter DATA_W = 10,
    parameter WORD_W = 16,
    parameter TIM_W  = 7
) (
    // Clock and reset
    input  wire              clock_i,
    input  wire              rst_b_i,
    // Baseband serial port
    input  wire              bb_frame_i,
    input  wire              bb_shift_i,
    input  wire              bb_din_i,
    input  wire              bb_burst_i,
    output wire              bb_dout_o,
    // Radio burst words
    output reg  [WORD_W-1:0] tx_word_o,
    output reg               tx_valid_o,
    input  wire [WORD_W-1:0] rx_word_i,
    input  wire              rx_load_i,
    // Micro serial port
    input  wire              micro_frame_i,
    input  wire              micro_shift_i,
    input  wire              micro_din_i,
    output wire              micro_dout_o,
    // Timing serial port
    input  wire              tim_frame_i,
    input  wire              tim_shift_i,
    input  wire              tim_din_i,
    // Real-time windows
    output reg               uplink_power_window_o,
    output reg               uplink_cal_window_o,
    output reg               uplink_tx_window_o,
    output reg               downlink_power_window_o,
    output reg               downlink_cal_window_o,
    output reg               downlink_rx_window_o,
    output reg               adc_conversion_window_o,
    // Current address pages
    output reg               micro_page_o,
    output reg               bb_page_o
);

    localparam ENTRIES = 2 << ADDR_W;

    // Received words from both access ports
    wire [WORD_W-1:0] bb_word;
    wire              bb_valid;
    wire [WORD_W-1:0] mc_word;
    wire              mc_valid;

    // Field split of each access word
    wire              bb_rw    = bb_word[`RW_BIT];
    wire [ADDR_W-1:0] bb_addr  = bb_word[`ADDR_MSB:`ADDR_LSB];    // [RQ3]
    wire [DATA_W-1:0] bb_data  = bb_word[`DATA_MSB:`DATA_LSB];    // [RQ4]
    wire              mc_rw    = mc_word[`RW_BIT];
    wire [ADDR_W-1:0] mc_addr  = mc_word[`ADDR_MSB:`ADDR_LSB];    // [RQ3]
    wire [DATA_W-1:0] mc_data  = mc_word[`DATA_MSB:`DATA_LSB];    // [RQ4]

    // Register accesses; burst words never touch the registers
    wire bb_reg   = bb_valid & ~bb_burst_i;
    wire bb_wr    = bb_reg & (bb_rw == `RW_WRITE);                 // [RQ1] [RQ7]
    wire bb_rd    = bb_reg & (bb_rw == `RW_READ);                  // [RQ2] [RQ7]
    wire mc_wr    = mc_valid & (mc_rw == `RW_WRITE);               // [RQ1] [RQ6]
    wire mc_rd    = mc_valid & (mc_rw == `RW_READ);                // [RQ2] [RQ6]

    // Page select decode ignores the page in force
    wire bb_psel  = bb_wr & (bb_addr == `PAGE_SEL_ADDR);           // [RQ9]
    wire mc_psel  = mc_wr & (mc_addr == `PAGE_SEL_ADDR);           // [RQ9]

    // Storage for both pages, index is {page, address}
    reg  [DATA_W-1:0] regs_q [0:ENTRIES-1];

    wire [ADDR_W:0]   bb_idx = {bb_page_o, bb_addr};
    wire [ADDR_W:0]   mc_idx = {micro_page_o, mc_addr};

    genvar e;
    generate
        for (e = 0; e < ENTRIES; e = e + 1) begin : g_entry
            wire [31:0]     idx_full = e;
            wire [ADDR_W:0] idx      = idx_full[ADDR_W:0];
            wire bb_hit = bb_wr & (bb_idx == idx);
            wire mc_hit = mc_wr & (mc_idx == idx);
            always @(posedge clock_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    regs_q[e] <= `REG_RESET;
                end else if (idx[ADDR_W-1:0] == `PAGE_SEL_ADDR) begin
                    // Page select bits are commands and hold no data
                    regs_q[e] <= `REG_RESET;                       // [RQ15]
                end else if (bb_hit) begin
                    // Baseband wins a same-cycle write to one register
                    regs_q[e] <= bb_data;                          // [RQ4] [RQ7]
                end else if (mc_hit) begin
                    regs_q[e] <= mc_data;                          // [RQ4] [RQ6]
                end
            end
        end
    endgenerate

    // Page selection; page 1 bit is honoured only with page 0 bit clear
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            micro_page_o <= `PAGE_RESET;                           // [RQ15]
            bb_page_o    <= `PAGE_RESET;                           // [RQ15]
        end else begin
            if (bb_psel) begin
                if (bb_data[`MICRO_P0_BIT]) begin
                    micro_page_o <= 1'b0;                          // [RQ10]
                end else if (bb_data[`MICRO_P1_BIT]) begin
                    micro_page_o <= 1'b1;                          // [RQ10]
                end
                if (bb_data[`BB_P0_BIT]) begin
                    bb_page_o <= 1'b0;                             // [RQ11]
                end else if (bb_data[`BB_P1_BIT]) begin
                    bb_page_o <= 1'b1;                             // [RQ11]
                end
            end else if (mc_psel) begin
                if (mc_data[`MICRO_P0_BIT]) begin
                    micro_page_o <= 1'b0;                          // [RQ10]
                end else if (mc_data[`MICRO_P1_BIT]) begin
                    micro_page_o <= 1'b1;                          // [RQ10]
                end
                if (mc_data[`BB_P0_BIT]) begin
                    bb_page_o <= 1'b0;                             // [RQ11]
                end else if (mc_data[`BB_P1_BIT]) begin
                    bb_page_o <= 1'b1;                             // [RQ11]
                end
            end
        end
    end

    // Read replies echo the address with bit 0 high; page select reads zero
    reg [DATA_W-1:0] bb_rdata;
    reg [DATA_W-1:0] mc_rdata;

    always @* begin
        bb_rdata = regs_q[bb_idx];                                 // [RQ5]
        mc_rdata = regs_q[mc_idx];                                 // [RQ5]
    end

    wire [WORD_W-1:0] bb_reply = bb_rd ? {bb_rdata, bb_addr, `RW_READ} : rx_word_i;
    wire              bb_load  = bb_rd | rx_load_i;                // [RQ8]
    wire [WORD_W-1:0] mc_reply = {mc_rdata, mc_addr, `RW_READ};

    serial_word_port #(
        .WORD_W (WORD_W),
        .CNT_W  (4)
    ) u_bb_port (
        .clock_i      (clock_i),
        .rst_b_i      (rst_b_i),
        .frame_i      (bb_frame_i),
        .shift_i      (bb_shift_i),
        .din_i        (bb_din_i),
        .dout_o       (bb_dout_o),
        .reply_i      (bb_reply),
        .reply_load_i (bb_load),
        .word_o       (bb_word),
        .word_valid_o (bb_valid)
    );

    serial_word_port #(
        .WORD_W (WORD_W),
        .CNT_W  (4)
    ) u_micro_port (
        .clock_i      (clock_i),
        .rst_b_i      (rst_b_i),
        .frame_i      (micro_frame_i),
        .shift_i      (micro_shift_i),
        .din_i        (micro_din_i),
        .dout_o       (micro_dout_o),
        .reply_i      (mc_reply),
        .reply_load_i (mc_rd),
        .word_o       (mc_word),
        .word_valid_o (mc_valid)
    );

    // Radio burst words received on the baseband port
    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_word_o  <= {WORD_W{1'b0}};
            tx_valid_o <= 1'b0;
        end else begin
            tx_valid_o <= bb_valid & bb_burst_i;                   // [RQ8]
            if (bb_valid && bb_burst_i) begin
                tx_word_o <= bb_word;                              // [RQ8]
            end
        end
    end

    // Timing serial port: 7-bit word, bit 6 first, applied after the last bit
    reg [TIM_W-1:0] tim_sh_q;
    reg [2:0]       tim_cnt_q;

    wire            tim_last = (tim_cnt_q == (TIM_W - 1));
    wire [TIM_W-1:0] tim_word = {tim_sh_q[TIM_W-2:0], tim_din_i};

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tim_sh_q                <= `TIMING_RESET;
            tim_cnt_q               <= 3'h0;
            uplink_power_window_o   <= 1'b0;
            uplink_cal_window_o     <= 1'b0;
            uplink_tx_window_o      <= 1'b0;
            downlink_power_window_o <= 1'b0;
            downlink_cal_window_o   <= 1'b0;
            downlink_rx_window_o    <= 1'b0;
            adc_conversion_window_o <= 1'b0;
        end else if (!tim_frame_i) begin
            tim_cnt_q <= 3'h0;
        end else if (tim_shift_i) begin
            tim_sh_q <= tim_word;
            if (tim_last) begin
                tim_cnt_q               <= 3'h0;
                uplink_power_window_o   <= tim_word[`UL_POWER_BIT];   // [RQ12]
                uplink_cal_window_o     <= tim_word[`UL_CAL_BIT];     // [RQ12]
                uplink_tx_window_o      <= tim_word[`UL_TX_BIT];      // [RQ12]
                downlink_power_window_o <= tim_word[`DL_POWER_BIT];   // [RQ13]
                downlink_cal_window_o   <= tim_word[`DL_CAL_BIT];     // [RQ13]
                downlink_rx_window_o    <= tim_word[`DL_RX_BIT];      // [RQ13]
                adc_conversion_window_o <= tim_word[`ADC_CONV_BIT];   // [RQ14]
            end else begin
                tim_cnt_q <= tim_cnt_q + 3'h1;
            end
        end
    end

endmodule // serial_register_access_ports

/* File: bench/serial_host_model.sv */
// Behavioural serial master that drives one port of the register block
module serial_host_model #(
    parameter int W         = 16,
    parameter bit LSB_FIRST = 1
) (
    input  wire logic clock_i,
    output logic      frame_o,
    output logic      shift_o,
    output logic      din_o,
    input  wire logic dout_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        frame_o = 1'b0;
        shift_o = 1'b0;
        din_o   = 1'b1;
    end
    // Sends one word, collecting what the port shifts back meanwhile
    task automatic xfer(input logic [W-1:0] word, output logic [W-1:0] reply);
        int b;
        for (int i = 0; i < W; i++) begin
            @(negedge clock_i);
            b = LSB_FIRST ? i : W - 1 - i;
            reply[b] = dout_i;
            frame_o  <= 1'b1;
            shift_o  <= 1'b1;
            din_o    <= word[b];
        end
        @(negedge clock_i);
        frame_o <= 1'b0;
        shift_o <= 1'b0;
        din_o   <= ~din_o;
        // Two idle edges let a read reply reach the out shifter
        repeat (2) @(negedge clock_i);
    endtask
endmodule // serial_host_model

/* File: bench/serial_register_access_ports_sva.sv */
// Concurrent checks on the ports of the register access block
module serial_register_access_ports_sva #(
    parameter WORD_W = 16
) (
    input wire logic              clock_i,
    input wire logic              rst_b_i,
    input wire logic              bb_frame_i,
    input wire logic              bb_shift_i,
    input wire logic              bb_burst_i,
    input wire logic [WORD_W-1:0] tx_word_o,
    input wire logic              tx_valid_o,
    input wire logic              micro_frame_i,
    input wire logic              micro_shift_i,
    input wire logic              micro_dout_o,
    input wire logic              tim_frame_i,
    input wire logic              tim_shift_i,
    input wire logic [6:0]        win,
    input wire logic              micro_page_o,
    input wire logic              bb_page_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic bb_stb;
    logic mi_stb;
    assign bb_stb = bb_frame_i && bb_shift_i;
    assign mi_stb = micro_frame_i && micro_shift_i;
    a_reset_state: assert property ($rose(rst_b_i) |-> !micro_page_o && !bb_page_o && win == 7'h00)
        else $error("state not cleared by reset");
    a_window_cause: assert property ($changed(win) |-> $past(tim_frame_i && tim_shift_i))
        else $error("window changed without timing strobe");
    a_tx_pulse: assert property (tx_valid_o |=> !tx_valid_o)
        else $error("tx valid longer than one cycle");
    a_tx_hold: assert property ($changed(tx_word_o) |-> tx_valid_o)
        else $error("tx word changed without valid");
    a_tx_cause: assert property (tx_valid_o |-> $past(bb_burst_i) && $past(bb_stb, 2))
        else $error("tx valid without burst word");
    a_micro_page_cause: assert property ($changed(micro_page_o) |-> $past(mi_stb, 3) || $past(bb_stb, 3))
        else $error("micro page changed without a word");
    a_bb_page_cause: assert property ($changed(bb_page_o) |-> $past(mi_stb, 3) || $past(bb_stb, 3))
        else $error("bb page changed without a word");
    a_micro_dout_idle: assert property (!micro_frame_i [*3] |=> $stable(micro_dout_o))
        else $error("micro dout moved while idle");
endmodule // serial_register_access_ports_sva

bind serial_register_access_ports serial_register_access_ports_sva #(.WORD_W(WORD_W)) sva_i (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .bb_frame_i(bb_frame_i), .bb_shift_i(bb_shift_i),
    .bb_burst_i(bb_burst_i), .tx_word_o(tx_word_o), .tx_valid_o(tx_valid_o), .micro_frame_i(micro_frame_i),
    .micro_shift_i(micro_shift_i), .micro_dout_o(micro_dout_o), .tim_frame_i(tim_frame_i),
    .tim_shift_i(tim_shift_i), .micro_page_o(micro_page_o), .bb_page_o(bb_page_o),
    .win({uplink_power_window_o, uplink_cal_window_o, uplink_tx_window_o, downlink_power_window_o,
          downlink_cal_window_o, downlink_rx_window_o, adc_conversion_window_o}));

/* File: bench/serial_register_access_ports_test.sv */
// Self-checking bench for the serial register access ports
`include "serial_port_map.vh"
module serial_register_access_ports_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        rst_b, bb_frame, bb_shift, bb_din, bb_burst, bb_dout, tx_valid, rx_load;
    logic        mi_frame, mi_shift, mi_din, mi_dout, tm_frame, tm_shift, tm_din, mi_page, bb_page;
    logic [6:0]  win, r7;
    logic [15:0] tx_word, rx_word, r;
    int          bad_count = 0;
    int          n_tests   = 0;
    int          tx_pulses = 0;
    // Rows: {port (1 micro), address, data}; read back through the other port
    logic [15:0] rows [4] = '{16'h03FF, 16'hFD55, 16'h0AAA, 16'hC001};
    logic [6:0]  tw [4]   = '{7'h55, 7'h2A, 7'h00, 7'h7F};
    always #2 clock = ~clock;
    serial_register_access_ports uut (
        .clock_i(clock), .rst_b_i(rst_b), .bb_frame_i(bb_frame), .bb_shift_i(bb_shift), .bb_din_i(bb_din),
        .bb_burst_i(bb_burst), .bb_dout_o(bb_dout), .tx_word_o(tx_word), .tx_valid_o(tx_valid),
        .rx_word_i(rx_word), .rx_load_i(rx_load), .micro_frame_i(mi_frame), .micro_shift_i(mi_shift),
        .micro_din_i(mi_din), .micro_dout_o(mi_dout), .tim_frame_i(tm_frame), .tim_shift_i(tm_shift),
        .tim_din_i(tm_din), .uplink_power_window_o(win[6]), .uplink_cal_window_o(win[5]),
        .uplink_tx_window_o(win[4]), .downlink_power_window_o(win[3]), .downlink_cal_window_o(win[2]),
        .downlink_rx_window_o(win[1]), .adc_conversion_window_o(win[0]), .micro_page_o(mi_page),
        .bb_page_o(bb_page));
    serial_host_model bb_m (.clock_i(clock), .frame_o(bb_frame), .shift_o(bb_shift),
        .din_o(bb_din), .dout_i(bb_dout));
    serial_host_model mi_m (.clock_i(clock), .frame_o(mi_frame), .shift_o(mi_shift),
        .din_o(mi_din), .dout_i(mi_dout));
    serial_host_model #(.W(7), .LSB_FIRST(0)) tm_m (.clock_i(clock), .frame_o(tm_frame), .shift_o(tm_shift),
        .din_o(tm_din), .dout_i(1'b0));
    // Burst valid stands one cycle, so it is counted at every falling edge
    always @(negedge clock) begin
        if (tx_valid === 1'b1) tx_pulses++;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic acc(input logic p, input logic [15:0] w, output logic [15:0] rep);
        if (p) mi_m.xfer(w, rep);
        else bb_m.xfer(w, rep);
    endtask
    function automatic logic [15:0] word(input logic rw, input logic [4:0] a, input logic [9:0] d);
        return {d, a, rw};
    endfunction
    // Read request with junk in the data field, then a frame that carries the reply out
    task automatic rd(input logic p, input logic [4:0] a, output logic [15:0] rep);
        acc(p, word(`RW_READ, a, 10'h3C5), rep);
        acc(p, word(`RW_READ, a, 10'h01A), rep);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        rst_b    = 1'b0;
        bb_burst = 1'b0;
        rx_load  = 1'b0;
        rx_word  = 16'h0000;
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        chk("pages at reset", 16'h0000, {14'h0000, mi_page, bb_page});
        $display("test reset done");
        foreach (rows[i]) begin
            acc(rows[i][15], word(`RW_WRITE, rows[i][14:10], rows[i][9:0]), r);
            repeat (2) begin
                rd(~rows[i][15], rows[i][14:10], r);
                chk("read back", {rows[i][9:0], rows[i][14:10], 1'b1}, r);
            end
        end
        $display("test rows done");
        rd(1'b1, `PAGE_SEL_ADDR, r);
        chk("page sel read", 16'h0003, r);
        acc(1'b1, word(`RW_WRITE, `PAGE_SEL_ADDR, 10'h002), r);
        chk("pages", 16'h0002, {14'h0000, mi_page, bb_page});
        acc(1'b1, word(`RW_WRITE, 5'h03, 10'h0F0), r);
        rd(1'b0, 5'h03, r);
        chk("bb page0 reg", 16'h0007, r);
        rd(1'b1, 5'h03, r);
        chk("micro page1 reg", 16'h3C07, r);
        rd(1'b1, `PAGE_SEL_ADDR, r);
        chk("page sel read p1", 16'h0003, r);
        acc(1'b0, word(`RW_WRITE, `PAGE_SEL_ADDR, 10'h3F8), r);
        chk("pages", 16'h0003, {14'h0000, mi_page, bb_page});
        rd(1'b0, 5'h03, r);
        chk("bb page1 reg", 16'h3C07, r);
        acc(1'b0, word(`RW_WRITE, `PAGE_SEL_ADDR, 10'h005), r);
        chk("pages", 16'h0000, {14'h0000, mi_page, bb_page});
        chk("tx pulses none", 16'h0000, tx_pulses[15:0]);
        $display("test pages done");
        bb_burst = 1'b1;
        acc(1'b0, 16'hC3A5, r);
        chk("tx word", 16'hC3A5, tx_word);
        rx_word = 16'h5A0F;
        rx_load = 1'b1;
        @(negedge clock);
        rx_load = 1'b0;
        acc(1'b0, 16'h1234, r);
        bb_burst = 1'b0;
        chk("rx word out", 16'h5A0F, r);
        chk("tx word", 16'h1234, tx_word);
        chk("tx pulses", 16'h0002, tx_pulses[15:0]);
        $display("test burst done");
        foreach (tw[i]) begin
            tm_m.xfer(tw[i], r7);
            chk("windows", {9'h000, tw[i]}, {9'h000, win});
        end
        $display("test timing done");
        acc(1'b1, word(`RW_WRITE, `PAGE_SEL_ADDR, 10'h00A), r);
        chk("pages before reset", 16'h0003, {14'h0000, mi_page, bb_page});
        rst_b = 1'b0;
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        chk("pages after reset", 16'h0000, {14'h0000, mi_page, bb_page});
        $display("test second reset done");
        close_out();
    end
    // Run needs about 780 cycles; allow well over ten times that
    initial begin
        #80000;
        bad_count++;
        $display("watchdog expired");
        close_out();
    end
endmodule // serial_register_access_ports_test
